// ### hw/ext_bus_ctrl.sv
// external memory bus control: strobes, fetch steering and port multiplexing
// assumes the core holds each request until done_o and drops it the next cycle
`timescale 1ns/1ps
module ext_bus_ctrl #(
  parameter int SLOT_CYCLES = ext_bus_pkg::STROBE_CYCLES
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic external_code_select_n_i,
  input wire logic latch_strobe_disable_i,
  input wire logic verify_mode_i,
  input wire logic [7:0] verify_byte_i,
  input wire logic fetch_req_i,
  input wire logic [15:0] pc_i,
  input wire logic move_req_i,
  input wire ext_bus_pkg::move_req_t move_i,
  input wire logic [7:0] low_port_latch_i,
  input wire logic [7:0] high_port_latch_i,
  input wire logic [7:0] low_bus_port_i,
  output logic [7:0] low_bus_port_o,
  output logic [7:0] low_bus_port_oe_o,
  output logic [7:0] high_bus_port_o,
  output logic high_bus_strong_o,
  output logic program_fetch_strobe_n_o,
  output logic address_latch_strobe_o,
  output logic read_strobe_n_o,
  output logic write_strobe_n_o,
  output logic done_o,
  output logic fetch_internal_o,
  output logic [7:0] rdata_o
);
  import ext_bus_pkg::*;

  localparam int SW = $clog2(SLOT_CYCLES);
  localparam logic [SW-1:0] LATCH_END = SW'(LATCH_HIGH_CYCLES);
  localparam logic [SW-1:0] HOLD_END = SW'(LATCH_HIGH_CYCLES + ADDR_HOLD_CYCLES);
  localparam logic [SW-1:0] SLOT_LAST = SW'(SLOT_CYCLES - 1);

  // ---------------------------------------------------------------
  // slot timing
  // ---------------------------------------------------------------
  logic [SW-1:0] slot_cnt;
  logic slot_last;

  bus_slot_timer #(
    .CYCLES(SLOT_CYCLES)
  ) u_timer (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .count_o(slot_cnt),
    .last_o(slot_last)
  );

  // phases within a slot: latch pulse, address hold, data
  logic in_latch;
  logic in_addr;
  assign in_latch = (slot_cnt < LATCH_END);
  assign in_addr = (slot_cnt < HOLD_END);

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  bus_state_t state_q;
  bus_state_t state_d;
  move_req_t move_q;
  move_req_t move_d;
  logic [15:0] fetch_addr_q;
  logic [15:0] fetch_addr_d;
  logic exec_internal_q;
  logic exec_internal_d;
  logic idle_latch_q;
  logic idle_latch_d;
  logic done_q;
  logic done_d;
  logic fetch_internal_q;
  logic fetch_internal_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic internal_target;
  logic can_take;

  // fetch target: pin high lets the lower code space run on chip
  assign internal_target = external_code_select_n_i && (pc_i < CODE_BOUNDARY);
  // a request seen with its own answer still standing is the old one
  assign can_take = !done_q;

  // pick the next transfer at a slot boundary; moves go before fetches
  always_comb begin
    state_d = state_q;
    move_d = move_q;
    fetch_addr_d = fetch_addr_q;
    exec_internal_d = exec_internal_q;
    idle_latch_d = idle_latch_q;
    done_d = 1'b0;
    fetch_internal_d = fetch_internal_q;
    rdata_d = rdata_q;
    case (state_q)
      ST_IDLE: begin
        if (can_take && fetch_req_i && !move_req_i && internal_target) begin
          // on-chip fetch needs no bus slot and is answered at once
          done_d = 1'b1;
          fetch_internal_d = 1'b1;
          exec_internal_d = 1'b1;
        end
      end
      ST_FETCH: begin
        if (slot_last) begin
          rdata_d = low_bus_port_i;
          done_d = 1'b1;
          fetch_internal_d = 1'b0;
          exec_internal_d = 1'b0;
          state_d = ST_IDLE;
        end
      end
      ST_MOVE1: begin
        if (slot_last) begin
          state_d = ST_MOVE2;
        end
      end
      ST_MOVE2: begin
        if (slot_last) begin
          if (!move_q.write) begin
            rdata_d = low_bus_port_i;
          end
          done_d = 1'b1;
          fetch_internal_d = 1'b0;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // a new slot starts here; off-chip transfers from idle wait for this edge, on-chip fetches are answered without it
    if (slot_last && (state_q == ST_IDLE) && can_take && !done_d) begin
      if (move_req_i) begin
        move_d = move_i;
        state_d = ST_MOVE1;
      end else if (fetch_req_i && !internal_target) begin
        fetch_addr_d = pc_i;
        state_d = ST_FETCH;
      end
    end
    // free-running latch pulses stop only for on-chip execution with the pin high
    if (slot_last) begin
      idle_latch_d = !(external_code_select_n_i && exec_internal_d && latch_strobe_disable_i);
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_IDLE;
      move_q <= '0;
      fetch_addr_q <= '0;
      exec_internal_q <= 1'b0;
      idle_latch_q <= 1'b1;
      done_q <= 1'b0;
      fetch_internal_q <= 1'b0;
      rdata_q <= BYTE_RESET;
    end else if (ce_i) begin
      state_q <= state_d;
      move_q <= move_d;
      fetch_addr_q <= fetch_addr_d;
      exec_internal_q <= exec_internal_d;
      idle_latch_q <= idle_latch_d;
      done_q <= done_d;
      fetch_internal_q <= fetch_internal_d;
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // pin values, one cycle ahead of the pins
  // ---------------------------------------------------------------
  logic fetch_strobe_n_d;
  logic latch_d;
  logic read_n_d;
  logic write_n_d;
  logic [7:0] high_d;
  logic high_strong_d;
  logic [7:0] low_addr;
  low_mode_t low_mode;

  // the pins lag this logic by one flop so every output leaves a register
  always_comb begin
    fetch_strobe_n_d = 1'b1;
    latch_d = 1'b0;
    read_n_d = 1'b1;
    write_n_d = 1'b1;
    high_d = high_port_latch_i;
    high_strong_d = 1'b0;
    low_addr = fetch_addr_q[7:0];
    low_mode = verify_mode_i ? LOW_VERIFY : LOW_GPIO;
    case (state_q)
      ST_IDLE: begin
        latch_d = in_latch && idle_latch_q;
      end
      ST_FETCH: begin
        latch_d = in_latch;
        high_d = fetch_addr_q[15:8];
        high_strong_d = 1'b1;
        low_mode = in_addr ? LOW_ADDR : LOW_RELEASE;
        fetch_strobe_n_d = in_addr;
      end
      ST_MOVE1: begin
        // the move's own address still needs one latch pulse
        latch_d = in_latch;
        low_addr = move_q.addr[7:0];
        high_d = move_q.wide ? move_q.addr[15:8] : high_port_latch_i;
        high_strong_d = move_q.wide;
        if (in_addr) begin
          low_mode = LOW_ADDR;
        end else if (move_q.write) begin
          low_mode = LOW_WDATA;
          write_n_d = 1'b0;
        end else begin
          low_mode = LOW_RELEASE;
          read_n_d = 1'b0;
        end
      end
      ST_MOVE2: begin
        // periodic latch and fetch strobes are skipped for this whole slot
        latch_d = 1'b0;
        fetch_strobe_n_d = 1'b1;
        low_addr = move_q.addr[7:0];
        high_d = move_q.wide ? move_q.addr[15:8] : high_port_latch_i;
        high_strong_d = move_q.wide;
        // data stands one cycle past the rising write strobe
        low_mode = move_q.write ? LOW_WDATA : LOW_RELEASE;
        write_n_d = !(move_q.write && slot_cnt != SLOT_LAST);
        read_n_d = !(!move_q.write && slot_cnt != SLOT_LAST);
      end
      default: begin
        latch_d = 1'b0;
      end
    endcase
  end

  logic fetch_strobe_n_q;
  logic latch_q;
  logic read_n_q;
  logic write_n_q;
  logic [7:0] high_q;
  logic high_strong_q;

  // strobes rest inactive in reset since the pins must not be fought
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fetch_strobe_n_q <= 1'b1;
      latch_q <= 1'b0;
      read_n_q <= 1'b1;
      write_n_q <= 1'b1;
      high_q <= BYTE_ONES;
      high_strong_q <= 1'b0;
    end else if (ce_i) begin
      fetch_strobe_n_q <= fetch_strobe_n_d;
      latch_q <= latch_d;
      read_n_q <= read_n_d;
      write_n_q <= write_n_d;
      high_q <= high_d;
      high_strong_q <= high_strong_d;
    end
  end

  low_port_driver #(
    .WIDTH(8)
  ) u_low (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .mode_i(low_mode),
    .addr_i(low_addr),
    .wdata_i(move_q.wdata),
    .latch_i(low_port_latch_i),
    .verify_i(verify_byte_i),
    .pad_o(low_bus_port_o),
    .pad_oe_o(low_bus_port_oe_o)
  );

  assign program_fetch_strobe_n_o = fetch_strobe_n_q;
  assign address_latch_strobe_o = latch_q;
  assign read_strobe_n_o = read_n_q;
  assign write_strobe_n_o = write_n_q;
  assign high_bus_port_o = high_q;
  assign high_bus_strong_o = high_strong_q;
  assign done_o = done_q;
  assign fetch_internal_o = fetch_internal_q;
  assign rdata_o = rdata_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_fetch_strobe_source;
    @(posedge clock_i) disable iff (!arst_n_i)
    !program_fetch_strobe_n_o |-> ($past(state_q) == ST_FETCH && read_strobe_n_o && write_strobe_n_o);
  endproperty
  a_fetch_strobe_source: assert property (p_fetch_strobe_source) else $error("fetch strobe outside a fetch");

  property p_fetch_strobe_internal;
    @(posedge clock_i) disable iff (!arst_n_i)
    (done_o && fetch_internal_o) |-> program_fetch_strobe_n_o;
  endproperty
  a_fetch_strobe_internal: assert property (p_fetch_strobe_internal) else $error("fetch strobe low on chip");

  property p_latch_width;
    @(posedge clock_i) disable iff (!arst_n_i)
    ($rose(address_latch_strobe_o) && ce_i ##1 ce_i) |-> address_latch_strobe_o ##1 !address_latch_strobe_o;
  endproperty
  a_latch_width: assert property (p_latch_width) else $error("latch pulse not two cycles");

  property p_latch_skip_move;
    @(posedge clock_i) disable iff (!arst_n_i)
    address_latch_strobe_o |-> ($past(state_q) != ST_MOVE2);
  endproperty
  a_latch_skip_move: assert property (p_latch_skip_move) else $error("latch pulse during data move");

  property p_latch_disabled;
    @(posedge clock_i) disable iff (!arst_n_i)
    (state_q == ST_IDLE && !idle_latch_q && ce_i) |=> !address_latch_strobe_o;
  endproperty
  a_latch_disabled: assert property (p_latch_disabled) else $error("latch pulse while disabled");

  property p_internal_fetch;
    @(posedge clock_i) disable iff (!arst_n_i)
    (state_q == ST_IDLE && fetch_req_i && !move_req_i && !done_q && ce_i && external_code_select_n_i
      && pc_i < CODE_BOUNDARY) |=> (done_o && fetch_internal_o && state_q == ST_IDLE);
  endproperty
  a_internal_fetch: assert property (p_internal_fetch) else $error("on-chip fetch not answered");

  property p_external_fetch;
    @(posedge clock_i) disable iff (!arst_n_i)
    (state_q == ST_IDLE && slot_last && fetch_req_i && !move_req_i && !done_q && ce_i
      && !external_code_select_n_i) |=> (state_q == ST_FETCH && fetch_addr_q == $past(pc_i));
  endproperty
  a_external_fetch: assert property (p_external_fetch) else $error("fetch not sent off chip");

  property p_addr_under_latch;
    @(posedge clock_i) disable iff (!arst_n_i)
    ($fell(address_latch_strobe_o) && $past(state_q) == ST_FETCH && $past(ce_i))
      |-> (low_bus_port_oe_o == BYTE_ONES && low_bus_port_o == fetch_addr_q[7:0]);
  endproperty
  a_addr_under_latch: assert property (p_addr_under_latch) else $error("address dropped at latch fall");

  property p_narrow_high;
    @(posedge clock_i) disable iff (!arst_n_i)
    ($past(ce_i) && ($past(state_q) == ST_MOVE2) && !$past(move_q.wide))
      |-> (high_bus_port_o == $past(high_port_latch_i) && !high_bus_strong_o);
  endproperty
  a_narrow_high: assert property (p_narrow_high) else $error("narrow move altered high port");

  property p_write_drives;
    @(posedge clock_i) disable iff (!arst_n_i)
    !write_strobe_n_o |-> (low_bus_port_oe_o == BYTE_ONES && low_bus_port_o == move_q.wdata && read_strobe_n_o);
  endproperty
  a_write_drives: assert property (p_write_drives) else $error("write strobe without data");

  property p_read_releases;
    @(posedge clock_i) disable iff (!arst_n_i)
    !read_strobe_n_o |-> (low_bus_port_oe_o == '0);
  endproperty
  a_read_releases: assert property (p_read_releases) else $error("bus driven during read");

endmodule

// ### hw/ext_bus_pkg.sv
// constants, types and timing for the external memory bus controller
// assumes a single 50 MHz clock and a core that holds requests until answered
package ext_bus_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  // oscillator period is not fixed by the bus, plain default
  localparam int OSC_PERIOD_NS = 100;
  // one and a half oscillator periods between strobes
  localparam int STROBE_INTERVAL_NS = (OSC_PERIOD_NS * 3) / 2;
  // least interval, so round up to whole cycles
  localparam int STROBE_CYCLES = (STROBE_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LATCH_HIGH_CYCLES = 2;
  localparam int ADDR_HOLD_CYCLES = 1;

  // ---------------------------------------------------------------
  // addresses and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] CODE_BOUNDARY = 16'h8000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_MOVE1 = 4'b0100,
    ST_MOVE2 = 4'b1000
  } bus_state_t;

  typedef enum logic [4:0] {
    LOW_GPIO    = 5'b00001,
    LOW_ADDR    = 5'b00010,
    LOW_WDATA   = 5'b00100,
    LOW_RELEASE = 5'b01000,
    LOW_VERIFY  = 5'b10000
  } low_mode_t;

  // one external data move as the core requests it
  typedef struct packed {
    logic write;
    logic wide;
    logic [15:0] addr;
    logic [7:0] wdata;
  } move_req_t;

endpackage

// ### hw/bus_slot_timer.sv
// bus slot counter: counts cycles within one strobe interval
// assumes the caller freezes it with the shared clock enable
`timescale 1ns/1ps
module bus_slot_timer #(
  parameter int CYCLES = ext_bus_pkg::STROBE_CYCLES
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  output logic [$clog2(CYCLES)-1:0] count_o,
  output logic last_o
);
  import ext_bus_pkg::*;

  localparam int W = $clog2(CYCLES);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // ---------------------------------------------------------------
  // free-running slot counter
  // ---------------------------------------------------------------
  // the counter keeps running while latch pulses are disabled; only a low ce_i stops it
  always_comb begin
    cnt_d = (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
    end
  end

  assign count_o = cnt_q;
  assign last_o = (cnt_q == LAST);

  property p_slot_wrap;
    @(posedge clock_i) disable iff (!arst_n_i)
    (last_o && ce_i) |=> (cnt_q == '0);
  endproperty
  a_slot_wrap: assert property (p_slot_wrap) else $error("slot counter did not wrap");

endmodule

// ### hw/low_port_driver.sv
// pad driver for the low bus port: open drain as I/O, strong as bus
// assumes the mode is chosen one cycle ahead by the bus sequencer
`timescale 1ns/1ps
module low_port_driver #(
  parameter int WIDTH = 8
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire ext_bus_pkg::low_mode_t mode_i,
  input wire logic [WIDTH-1:0] addr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [WIDTH-1:0] latch_i,
  input wire logic [WIDTH-1:0] verify_i,
  output logic [WIDTH-1:0] pad_o,
  output logic [WIDTH-1:0] pad_oe_o
);
  import ext_bus_pkg::*;

  logic [WIDTH-1:0] out_d;
  logic [WIDTH-1:0] oe_d;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] oe_q;

  // ---------------------------------------------------------------
  // per-pin drive choice
  // ---------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    always_comb begin
      out_d[i] = 1'b0;
      oe_d[i] = 1'b0;
      case (mode_i)
        LOW_ADDR: begin
          out_d[i] = addr_i[i];
          oe_d[i] = 1'b1;
        end
        LOW_WDATA: begin
          out_d[i] = wdata_i[i];
          oe_d[i] = 1'b1;
        end
        LOW_VERIFY: begin
          // only zeros are pulled, the tester pulls ones up
          oe_d[i] = ~verify_i[i];
        end
        LOW_GPIO: begin
          oe_d[i] = ~latch_i[i];
        end
        default: begin
          oe_d[i] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_q <= '0;
      oe_q <= '0;
    end else if (ce_i) begin
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  assign pad_o = out_q;
  assign pad_oe_o = oe_q;

  property p_bus_strong;
    @(posedge clock_i) disable iff (!arst_n_i)
    ($past(arst_n_i) && $past(ce_i) && ($past(mode_i) == LOW_ADDR || $past(mode_i) == LOW_WDATA))
      |-> (pad_oe_o == '1);
  endproperty
  a_bus_strong: assert property (p_bus_strong) else $error("bus mode left a pin undriven");

  property p_gpio_open_drain;
    @(posedge clock_i) disable iff (!arst_n_i)
    // the flops still held reset at the releasing edge, so that edge is no reference
    ($past(arst_n_i) && $past(ce_i) && $past(mode_i) == LOW_GPIO)
      |-> (pad_o == '0 && pad_oe_o == ~$past(latch_i));
  endproperty
  a_gpio_open_drain: assert property (p_gpio_open_drain) else $error("gpio pin not open drain");

  property p_verify_pull;
    @(posedge clock_i) disable iff (!arst_n_i)
    ($past(arst_n_i) && $past(ce_i) && $past(mode_i) == LOW_VERIFY)
      |-> (pad_o == '0 && pad_oe_o == ~$past(verify_i));
  endproperty
  a_verify_pull: assert property (p_verify_pull) else $error("verify byte not driven open drain");

endmodule

// ### testbench/ext_mem_model.sv
// external program and data memory with its address latch, seen from the pins
// assumes the bench resolves the low port wire from the controller enables alone
`timescale 1ns/1ps
module ext_mem_model (
  input wire logic clock_i,
  input wire logic [7:0] low_i,
  input wire logic [7:0] high_i,
  input wire logic latch_i,
  input wire logic fetch_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic [15:0] wr_addr_o,
  output logic [7:0] wr_data_o
);
  logic [15:0] addr_q = 16'h0000;
  logic latch_q = 1'b0;
  logic wr_n_q = 1'b1;
  logic [7:0] last_q = 8'h00;

  // ----------------------------------------
  // address latch and write capture
  // ----------------------------------------
  // address is taken as the strobe falls, so an early address removal shows up
  always @(posedge clock_i) begin
    latch_q <= latch_i;
    wr_n_q <= wr_n_i;
    if (latch_q && !latch_i) addr_q <= {high_i, low_i};
    if (!wr_n_q && wr_n_i) begin
      wr_addr_o <= addr_q;
      wr_data_o <= low_i;
    end
    if (data_oe_o) last_q <= data_o;
  end

  // strobes are inputs here only: the memory never drives them, in reset or after
  // drive only while enabled; released, show the inverse so a stale byte never passes
  assign data_oe_o = !fetch_n_i || !rd_n_i;
  assign data_o = data_oe_o ? (addr_q[7:0] ^ addr_q[15:8] ^ 8'h3C) : ~last_q;
endmodule

// ### testbench/external_memory_bus_control_tb.sv
// self-checking bench for the external memory bus controller
// assumes ext_bus_pkg and the partner memory model are compiled first
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); end end
module external_memory_bus_control_tb;
  import ext_bus_pkg::*;
  logic clock_i = 1'b0;
  logic arst_n_i, ce_i, external_code_select_n_i, latch_strobe_disable_i, verify_mode_i;
  logic fetch_req_i, move_req_i, program_fetch_strobe_n_o, address_latch_strobe_o;
  logic read_strobe_n_o, write_strobe_n_o, done_o, fetch_internal_o, high_bus_strong_o;
  logic [7:0] verify_byte_i, low_port_latch_i, high_port_latch_i, pad, low_bus_port_o;
  logic [7:0] low_bus_port_oe_o, high_bus_port_o, rdata_o, mem_data, wr_data, hl;
  logic [15:0] pc_i, a, eff, wr_addr;
  move_req_t move_i, mv;
  logic mem_oe, pin, int_exp;
  logic fetch_q = 1'b1;
  logic latch_q = 1'b0;
  int n_fail = 0;
  int samples_checked = 0;
  int n_fall, n_rise, seed;

  always #10 clock_i = ~clock_i;

  // pins not driven fall back to the tester pullups in verify mode
  assign pad = (low_bus_port_oe_o & low_bus_port_o) | (~low_bus_port_oe_o & (verify_mode_i ? 8'hFF : mem_data));

  ext_bus_ctrl i_dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
    .external_code_select_n_i(external_code_select_n_i), .latch_strobe_disable_i(latch_strobe_disable_i),
    .verify_mode_i(verify_mode_i), .verify_byte_i(verify_byte_i), .fetch_req_i(fetch_req_i), .pc_i(pc_i),
    .move_req_i(move_req_i), .move_i(move_i), .low_port_latch_i(low_port_latch_i),
    .high_port_latch_i(high_port_latch_i), .low_bus_port_i(pad), .low_bus_port_o(low_bus_port_o),
    .low_bus_port_oe_o(low_bus_port_oe_o), .high_bus_port_o(high_bus_port_o),
    .high_bus_strong_o(high_bus_strong_o), .program_fetch_strobe_n_o(program_fetch_strobe_n_o),
    .address_latch_strobe_o(address_latch_strobe_o), .read_strobe_n_o(read_strobe_n_o),
    .write_strobe_n_o(write_strobe_n_o), .done_o(done_o), .fetch_internal_o(fetch_internal_o),
    .rdata_o(rdata_o));

  ext_mem_model i_mem (.clock_i(clock_i), .low_i(pad), .high_i(high_bus_port_o),
    .latch_i(address_latch_strobe_o), .fetch_n_i(program_fetch_strobe_n_o), .rd_n_i(read_strobe_n_o),
    .wr_n_i(write_strobe_n_o), .data_o(mem_data), .data_oe_o(mem_oe), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data));

  function automatic logic [7:0] mem_f(input logic [15:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h3C;
  endfunction

  // ----------------------------------------
  // pin monitor: strobe edges and address phase
  // ----------------------------------------
  always @(posedge clock_i) begin
    fetch_q <= program_fetch_strobe_n_o;
    latch_q <= address_latch_strobe_o;
    if (fetch_q && !program_fetch_strobe_n_o) n_fall++;
    if (address_latch_strobe_o && !latch_q) n_rise++;
    if (address_latch_strobe_o && high_bus_strong_o) `CHK(low_bus_port_oe_o, 8'hFF)
  end

  // one request held until done, dropped at the following edge
  task automatic run(input logic mv_sel);
    int k;
    k = 0;
    @(posedge clock_i);
    if (mv_sel) move_req_i <= 1'b1;
    else fetch_req_i <= 1'b1;
    do begin
      @(posedge clock_i);
      #1 k++;
    end while (done_o !== 1'b1 && k < 60);
    if (k >= 60) n_fail++;
    @(posedge clock_i);
    fetch_req_i <= 1'b0;
    move_req_i <= 1'b0;
    #1;
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'hBE519A4D;
    arst_n_i = 1'b0;
    ce_i = 1'b1;
    external_code_select_n_i = 1'b1;
    {latch_strobe_disable_i, verify_mode_i, fetch_req_i, move_req_i} = 4'h0;
    verify_byte_i = 8'h00;
    pc_i = 16'h0000;
    move_i = '0;
    low_port_latch_i = 8'hFF;
    high_port_latch_i = 8'h00;
    @(posedge clock_i);
    #1;
    `CHK(program_fetch_strobe_n_o, 1'b1)
    `CHK(low_bus_port_oe_o, 8'h00)
    @(posedge clock_i);
    arst_n_i <= 1'b1;
    low_port_latch_i <= 8'($random(seed));
    repeat (3) @(posedge clock_i);
    #1;
    `CHK(low_bus_port_oe_o, ~low_port_latch_i)
    @(posedge clock_i);
    verify_mode_i <= 1'b1;
    verify_byte_i <= 8'h5A;
    repeat (3) @(posedge clock_i);
    #1;
    `CHK(pad, 8'h5A)
    verify_mode_i <= 1'b0;
    // on-chip code, then the disable stops free pulses only while the pin is high
    pc_i <= 16'h0100;
    run(1'b0);
    latch_strobe_disable_i <= 1'b1;
    // counters are cleared and read off the edge so the monitor never races them
    repeat (16) @(posedge clock_i);
    #1 n_rise = 0;
    repeat (32) @(posedge clock_i);
    #1;
    `CHK(n_rise, 0)
    external_code_select_n_i <= 1'b0;
    repeat (16) @(posedge clock_i);
    #1 n_rise = 0;
    repeat (32) @(posedge clock_i);
    #1;
    `CHK(n_rise, 4)
    // a low clock enable freezes the pulse train wherever it stands
    ce_i <= 1'b0;
    @(posedge clock_i);
    #1 n_rise = 0;
    a = {7'h00, address_latch_strobe_o, low_bus_port_oe_o};
    repeat (20) @(posedge clock_i);
    #1;
    eff = {7'h00, address_latch_strobe_o, low_bus_port_oe_o};
    `CHK(eff, a)
    `CHK(n_rise, 0)
    ce_i <= 1'b1;
    latch_strobe_disable_i <= 1'b0;
    // fetches, boundary addresses first
    for (int i = 0; i < 24; i++) begin
      pin = (i < 2) ? 1'b1 : 1'($random(seed));
      a = (i == 0) ? 16'h7FFF : (i == 1) ? 16'h8000 : 16'($random(seed));
      int_exp = pin && (a < 16'h8000);
      external_code_select_n_i <= pin;
      pc_i <= a;
      n_fall = 0;
      run(1'b0);
      `CHK(fetch_internal_o, int_exp)
      `CHK(n_fall, int_exp ? 0 : 1)
      if (!int_exp) `CHK(rdata_o, mem_f(a))
    end
    // data moves back to back, writes and reads, wide and narrow
    for (int i = 0; i < 16; i++) begin
      mv.write = i[0];
      mv.wide = 1'($random(seed));
      mv.addr = 16'($random(seed));
      mv.wdata = 8'($random(seed));
      hl = 8'($random(seed));
      eff = mv.wide ? mv.addr : {hl, mv.addr[7:0]};
      move_i <= mv;
      high_port_latch_i <= hl;
      n_fall = 0;
      run(1'b1);
      `CHK(n_fall, 0)
      if (mv.write) begin
        `CHK(wr_addr, eff)
        `CHK(wr_data, mv.wdata)
      end else `CHK(rdata_o, mem_f(eff))
    end
    stop_test();
  end

  // cut a hang short well past the expected run length
  initial begin
    #(20 * 20000);
    n_fail++;
    stop_test();
  end
endmodule
